// ---- lbram_chk.sv ----
// concurrent checks on the large dual-port ram top ports
`timescale 1ns/1ps

module lbram_chk (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // wishbone
  input wire logic WB_WE_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  // memory ports
  input wire logic A_CE,
  input wire logic A_CLR,
  input wire logic A_WE,
  input wire logic [71:0] A_DOUT,
  input wire logic B_CE,
  input wire logic B_CLR,
  input wire logic B_WE,
  input wire logic [71:0] B_DOUT
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // ==========================================
  // helper: any read request on either port
  logic rd_any;
  assign rd_any = (A_CE && !A_WE) || (B_CE && !B_WE);
  // ==========================================
  // assertions
  a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held too long");
  a_ack_next_cycle: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack late");
  a_ack_has_req: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  a_rdat_on_read: assert property ($changed(WB_DAT_O) |-> WB_ACK_O && !WB_WE_I)
    else $error("read data moved without read");
  a_clear_port_a: assert property (A_CLR |-> A_DOUT == 72'h0)
    else $error("port a clear ignored");
  a_clear_port_b: assert property (B_CLR |-> B_DOUT == 72'h0)
    else $error("port b clear ignored");
  // halves of a wide read may land on either output, so any read is a cause
  a_dout_a_cause: assert property (!A_CLR && !$past(A_CLR) && $changed(A_DOUT)
    |-> $past(rd_any, 2) || $past(rd_any, 3))
    else $error("port a data moved without read");
  a_dout_b_cause: assert property (!B_CLR && !$past(B_CLR) && $changed(B_DOUT)
    |-> $past(rd_any, 2) || $past(rd_any, 3))
    else $error("port b data moved without read");
  // ==========================================
  // covers
  c_write_a: cover property (A_CE && A_WE);
  c_read_b: cover property (B_CE && !B_WE);
  c_clear_a: cover property (A_CLR);
  c_clear_b: cover property (B_CLR);
endmodule

bind lbram_top lbram_chk u_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .A_CE(A_CE), .A_CLR(A_CLR), .A_WE(A_WE),
  .A_DOUT(A_DOUT), .B_CE(B_CE), .B_CLR(B_CLR), .B_WE(B_WE), .B_DOUT(B_DOUT));

// ---- lbram_pkg.sv ----
// shared types of the large dual-port ram
package lbram_pkg;

  // ==========================================
  // operating modes
  typedef enum logic [1:0] {
    LBRAM_TDP,
    LBRAM_SDP,
    LBRAM_SP,
    LBRAM_FIFO
  } lbram_mode_t;

endpackage

// ---- lbram_port.sv ----
// one port: input registers and mapping between user words and 9-bit array lanes
`timescale 1ns/1ps
`include "lbram_regs.svh"

module lbram_port (
  // clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  // user request
  input wire logic ce,
  input wire logic we,
  input wire logic [15:0] addr,
  input wire logic [143:0] din,
  input wire logic [15:0] be,
  // configuration
  input wire logic [2:0] wcode,
  input wire logic byte8,
  input wire logic mask_en,
  // array side
  input wire logic [143:0] row_word,
  output logic [11:0] row,
  output logic op,
  output logic wr,
  output logic [15:0] lane_we,
  output logic [143:0] lane_data,
  output logic [143:0] rd_word
);

  // ==========================================
  // input registers
  logic [15:0] addr_q, addr_d;
  logic we_q, we_d;
  logic op_q, op_d;
  logic [143:0] din_q, din_d;
  logic [15:0] be_q, be_d;

  always_comb begin
    addr_d = addr_q;
    we_d = we_q;
    din_d = din_q;
    be_d = be_q;
    op_d = 1'b0;
    if (ce) begin
      addr_d = addr;
      we_d = we;
      din_d = din;
      be_d = be;
      op_d = 1'b1;
    end
  end

  // clear is taken at once, array contents untouched
  always_ff @(posedge clk or posedge rst or posedge clr) begin
    if (rst || clr) begin
      addr_q <= 16'h0;
      we_q <= 1'b0;
      op_q <= 1'b0;
      din_q <= 144'h0;
      be_q <= 16'h0;
    end else begin
      addr_q <= addr_d;
      we_q <= we_d;
      op_q <= op_d;
      din_q <= din_d;
      be_q <= be_d;
    end
  end

  // ==========================================
  // lane mapping
  logic [2:0] shift;
  logic [3:0] seg;
  logic [15:0] be_eff;
  logic [143:0] r9;
  logic [127:0] r8;

  assign shift = 3'h4 - wcode;
  assign row = 12'(addr_q >> shift);
  assign seg = 4'(addr_q & ((16'h1 << shift) - 16'h1));
  // a one-lane word has nothing to mask
  assign be_eff = (mask_en && wcode != 3'h0) ? be_q : 16'hffff;
  assign op = op_q;
  assign wr = we_q;

  generate
    for (genvar j = 0; j < 16; j++) begin : g_lane
      localparam logic [3:0] LJ = 4'(j);
      logic own;
      logic [3:0] loc;
      logic [3:0] idx;
      logic inr;
      assign own = (4'(LJ >> wcode) == seg);
      assign loc = LJ & 4'((5'h1 << wcode) - 5'h1);
      assign lane_we[j] = op_q & we_q & own & be_eff[loc];
      assign lane_data[9*j +: 9] = byte8 ? {1'b0, din_q[8*loc +: 8]} : din_q[9*loc +: 9];
      assign idx = 4'(seg << wcode) | LJ;
      assign inr = (4'(LJ >> wcode) == 4'h0);
      assign r9[9*j +: 9] = inr ? row_word[9*idx +: 9] : 9'h0;
      assign r8[8*j +: 8] = inr ? row_word[9*idx +: 8] : 8'h0;
    end
  endgenerate

  assign rd_word = byte8 ? {16'h0, r8} : r9;

endmodule

// ---- lbram_regs.svh ----
// register offsets, field positions, reset values and sizes of the large dual-port ram
`ifndef LBRAM_REGS_SVH
`define LBRAM_REGS_SVH

// ==========================================
// register offsets (byte addresses)
`define LBRAM_ADR_CONFIG 4'h0
`define LBRAM_ADR_STATUS 4'h4
`define LBRAM_ADR_LEVEL 4'h8

// ==========================================
// config fields
`define LBRAM_CFG_MODE_LSB 0
`define LBRAM_CFG_WA_LSB 2
`define LBRAM_CFG_WB_LSB 5
`define LBRAM_CFG_BYP_A 8
`define LBRAM_CFG_BYP_B 9
`define LBRAM_CFG_B8_A 10
`define LBRAM_CFG_B8_B 11
`define LBRAM_CFG_MASK_A 12
`define LBRAM_CFG_MASK_B 13
`define LBRAM_CFG_WMASK 32'h00003fff
`define LBRAM_CFG_RESET 32'h0000006c

// ==========================================
// status fields
`define LBRAM_STA_ERR 0
`define LBRAM_STA_EMPTY 1
`define LBRAM_STA_FULL 2

// ==========================================
// array geometry
`define LBRAM_TOTAL_BITS 589824
`define LBRAM_ROWS 4096
`define LBRAM_LANES 16
`define LBRAM_W144 3'h4
`define LBRAM_FIFO_SPAN 17'h10000

`endif

// ---- lbram_top.sv ----
// large dual-port ram: array, two ports, fifo pointers and wishbone config slave
`timescale 1ns/1ps
`include "lbram_regs.svh"

// What this block does
// - array holds 589,824 bits, parity bits included.
// - runs as true dual-port, simple dual-port, single-port or fifo storage.
// - no preload; contents undefined until written.
// - every input is registered before touching the array.
// - each read path may bypass its output register.
// - depths and widths from 64K x 8/9 down to 4K x 128/144.
// - 144-bit organization refused in true dual-port mode.
// - simple dual-port mixes 9 to 72 freely; 144 only on both sides.
// - true dual-port ports independently 9 to 72 bits wide.
// - one write enable per port picks write or read.
// - lane written only with write enable and its mask bit; mask defaults ones.
// - byte masks for 18, 36 and 72 bit widths, one per 9-bit lane.
// - 144-bit simple dual-port joins both 8-bit masks into sixteen.
// - mask bit i guards data bits 9i to 9i+8.
// - any mask mix; 8-bit lanes in 16/32/64/128 widths.
// - write enable, data, address and mask registered on one clock.
// - each port has 72 data inputs and 72 data outputs.
// - true dual-port: each port's registers use its own enable and clear.
// - simple dual-port: write side and read side registered separately.
// - a port's inputs and its data output registered separately.

module lbram_top (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // wishbone slave
  input wire logic [3:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // port a
  input wire logic A_CE,
  input wire logic A_CLR,
  input wire logic A_WE,
  input wire logic [15:0] A_ADDR,
  input wire logic [71:0] A_DIN,
  input wire logic [7:0] A_BE,
  output logic [71:0] A_DOUT,
  // port b
  input wire logic B_CE,
  input wire logic B_CLR,
  input wire logic B_WE,
  input wire logic [15:0] B_ADDR,
  input wire logic [71:0] B_DIN,
  input wire logic [7:0] B_BE,
  output logic [71:0] B_DOUT
);

  // ==========================================
  // configuration decode
  logic [31:0] cfg_q, cfg_d;
  lbram_pkg::lbram_mode_t mode;
  logic [2:0] wa, wb;
  logic cfg_err;
  logic is_fifo;
  logic hi_on_a;

  assign mode = lbram_pkg::lbram_mode_t'(cfg_q[`LBRAM_CFG_MODE_LSB +: 2]);
  assign wa = cfg_q[`LBRAM_CFG_WA_LSB +: 3];
  assign wb = cfg_q[`LBRAM_CFG_WB_LSB +: 3];
  assign is_fifo = (mode == lbram_pkg::LBRAM_FIFO);
  // the wide read word needs all 144 output drivers, so port a carries its upper half
  assign hi_on_a = (mode == lbram_pkg::LBRAM_SDP || is_fifo) && wb == `LBRAM_W144;

  always_comb begin
    cfg_err = (wa > `LBRAM_W144) || (wb > `LBRAM_W144);
    if (mode == lbram_pkg::LBRAM_TDP && (wa == `LBRAM_W144 || wb == `LBRAM_W144)) begin
      cfg_err = 1'b1;
    end
    if (mode == lbram_pkg::LBRAM_SDP && ((wa == `LBRAM_W144) != (wb == `LBRAM_W144))) begin
      cfg_err = 1'b1;
    end
    // pointers count words, so both fifo sides share one width
    if (is_fifo && wa != wb) begin
      cfg_err = 1'b1;
    end
  end

  // ==========================================
  // fifo pointers
  logic [15:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [16:0] level_q, level_d;
  logic [16:0] depth;
  logic [15:0] ptr_mask;
  logic full, empty, push, pop;

  assign depth = `LBRAM_FIFO_SPAN >> wa;
  assign ptr_mask = 16'(depth - 17'h1);
  assign full = (level_q == depth);
  assign empty = (level_q == 17'h0);
  assign push = is_fifo && !cfg_err && A_CE && A_WE && !full;
  assign pop = is_fifo && !cfg_err && B_CE && !B_WE && !empty;

  always_comb begin
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    level_d = level_q;
    if (push) begin
      wr_ptr_d = (wr_ptr_q + 16'h1) & ptr_mask;
    end
    if (pop) begin
      rd_ptr_d = (rd_ptr_q + 16'h1) & ptr_mask;
    end
    if (push && !pop) begin
      level_d = level_q + 17'h1;
    end else if (pop && !push) begin
      level_d = level_q - 17'h1;
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_ptr_q <= 16'h0;
      rd_ptr_q <= 16'h0;
      level_q <= 17'h0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      level_q <= level_d;
    end
  end

  // ==========================================
  // ports
  logic a_ce, a_we, b_ce, b_we;
  logic [15:0] a_addr, b_addr;
  logic [11:0] a_row, b_row;
  logic a_op, a_wr, b_op, b_wr;
  logic [15:0] a_lwe, b_lwe;
  logic [143:0] a_ld, b_ld, a_word, b_word, a_rd, b_rd;

  assign a_ce = is_fifo ? push : (A_CE && !cfg_err);
  assign a_we = A_WE;
  assign a_addr = is_fifo ? wr_ptr_q : A_ADDR;
  // only true dual-port lets port b write; single-port keeps it off, elsewhere it is the read side
  assign b_ce = is_fifo ? pop : (B_CE && !cfg_err && mode != lbram_pkg::LBRAM_SP);
  assign b_we = B_WE && mode == lbram_pkg::LBRAM_TDP;
  assign b_addr = is_fifo ? rd_ptr_q : B_ADDR;

  lbram_port u_port_a (
    .clk(CLOCK),
    .rst(SYS_RST),
    .clr(A_CLR),
    .ce(a_ce),
    .we(a_we),
    .addr(a_addr),
    .din({B_DIN, A_DIN}),
    .be({B_BE, A_BE}),
    .wcode(wa),
    .byte8(cfg_q[`LBRAM_CFG_B8_A]),
    .mask_en(cfg_q[`LBRAM_CFG_MASK_A]),
    .row_word(a_word),
    .row(a_row),
    .op(a_op),
    .wr(a_wr),
    .lane_we(a_lwe),
    .lane_data(a_ld),
    .rd_word(a_rd)
  );

  lbram_port u_port_b (
    .clk(CLOCK),
    .rst(SYS_RST),
    .clr(B_CLR),
    .ce(b_ce),
    .we(b_we),
    .addr(b_addr),
    .din({72'h0, B_DIN}),
    .be({8'h0, B_BE}),
    .wcode(wb),
    .byte8(cfg_q[`LBRAM_CFG_B8_B]),
    .mask_en(cfg_q[`LBRAM_CFG_MASK_B]),
    .row_word(b_word),
    .row(b_row),
    .op(b_op),
    .wr(b_wr),
    .lane_we(b_lwe),
    .lane_data(b_ld),
    .rd_word(b_rd)
  );

  // ==========================================
  // storage array, 4096 rows of sixteen 9-bit lanes
  logic [143:0] mem [0:`LBRAM_ROWS-1];

  // no reset and no preload: rows read as unknown until written
  always_ff @(posedge CLOCK) begin
    for (int j = 0; j < `LBRAM_LANES; j++) begin
      if (a_lwe[j]) begin
        mem[a_row][9*j +: 9] <= a_ld[9*j +: 9];
      end
      if (b_lwe[j]) begin
        mem[b_row][9*j +: 9] <= b_ld[9*j +: 9];
      end
    end
  end

  // reads see old contents; a same-lane collision leaves port b's data
  assign a_word = mem[a_row];
  assign b_word = mem[b_row];

  // ==========================================
  // read pipeline, port b
  logic rd_b;
  logic [143:0] arr_b_q, arr_b_d;
  logic arr_bv_q, arr_bv_d;
  logic [71:0] dout_b_q, dout_b_d;

  assign rd_b = b_op && !b_wr;

  always_comb begin
    arr_b_d = rd_b ? b_rd : arr_b_q;
    arr_bv_d = rd_b;
    dout_b_d = dout_b_q;
    if (cfg_q[`LBRAM_CFG_BYP_B]) begin
      if (rd_b) begin
        dout_b_d = b_rd[71:0];
      end
    end else if (arr_bv_q) begin
      dout_b_d = arr_b_q[71:0];
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST or posedge B_CLR) begin
    if (SYS_RST || B_CLR) begin
      arr_b_q <= 144'h0;
      arr_bv_q <= 1'b0;
      dout_b_q <= 72'h0;
    end else begin
      arr_b_q <= arr_b_d;
      arr_bv_q <= arr_bv_d;
      dout_b_q <= dout_b_d;
    end
  end

  // ==========================================
  // read pipeline, port a
  logic rd_a;
  logic [71:0] arr_a_q, arr_a_d;
  logic arr_av_q, arr_av_d;
  logic [71:0] dout_a_q, dout_a_d;

  assign rd_a = a_op && !a_wr && (mode == lbram_pkg::LBRAM_TDP || mode == lbram_pkg::LBRAM_SP);

  always_comb begin
    arr_a_d = rd_a ? a_rd[71:0] : arr_a_q;
    arr_av_d = rd_a;
    dout_a_d = dout_a_q;
    if (hi_on_a) begin
      if (cfg_q[`LBRAM_CFG_BYP_B]) begin
        if (rd_b) begin
          dout_a_d = b_rd[143:72];
        end
      end else if (arr_bv_q) begin
        dout_a_d = arr_b_q[143:72];
      end
    end else if (cfg_q[`LBRAM_CFG_BYP_A]) begin
      if (rd_a) begin
        dout_a_d = a_rd[71:0];
      end
    end else if (arr_av_q) begin
      dout_a_d = arr_a_q;
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST or posedge A_CLR) begin
    if (SYS_RST || A_CLR) begin
      arr_a_q <= 72'h0;
      arr_av_q <= 1'b0;
      dout_a_q <= 72'h0;
    end else begin
      arr_a_q <= arr_a_d;
      arr_av_q <= arr_av_d;
      dout_a_q <= dout_a_d;
    end
  end

  assign A_DOUT = dout_a_q;
  assign B_DOUT = dout_b_q;

  // ==========================================
  // wishbone slave
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic req;

  assign req = WB_CYC_I && WB_STB_I && !ack_q;

  always_comb begin
    ack_d = req;
    dat_d = dat_q;
    cfg_d = cfg_q;
    if (req && !WB_WE_I) begin
      case (WB_ADR_I)
        `LBRAM_ADR_CONFIG: dat_d = cfg_q;
        `LBRAM_ADR_STATUS: dat_d = {29'h0, full, empty, cfg_err};
        `LBRAM_ADR_LEVEL: dat_d = {15'h0, level_q};
        default: dat_d = 32'h0;
      endcase
    end
    if (req && WB_WE_I && WB_ADR_I == `LBRAM_ADR_CONFIG) begin
      for (int i = 0; i < 4; i++) begin
        if (WB_SEL_I[i]) begin
          cfg_d[8*i +: 8] = 8'(WB_DAT_I[8*i +: 8] & (`LBRAM_CFG_WMASK >> (8*i)));
        end
      end
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
      cfg_q <= `LBRAM_CFG_RESET;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
      cfg_q <= cfg_d;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;

endmodule

// ---- lbram_top_tb.sv ----
// self-checking bench of the large dual-port ram
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end

module lbram_top_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] wb_adr = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic wb_we = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack;
  logic a_ce, a_clr, a_we, b_ce, b_clr, b_we;
  logic [15:0] a_addr, b_addr;
  logic [71:0] a_din, a_dout, b_din, b_dout, q, x, y, m;
  logic [7:0] a_be, b_be;
  logic [31:0] r;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  // ==========================================
  // clock, timeout, instances
  always #4 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      wrap_up();
    end
  end
  lbram_top u_lbram_top (.CLOCK(clock), .SYS_RST(sys_rst), .WB_ADR_I(wb_adr), .WB_DAT_I(wb_dat_i),
    .WB_WE_I(wb_we), .WB_SEL_I(4'hf), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_DAT_O(wb_dat_o),
    .WB_ACK_O(wb_ack), .A_CE(a_ce), .A_CLR(a_clr), .A_WE(a_we), .A_ADDR(a_addr), .A_DIN(a_din),
    .A_BE(a_be), .A_DOUT(a_dout), .B_CE(b_ce), .B_CLR(b_clr), .B_WE(b_we), .B_ADDR(b_addr),
    .B_DIN(b_din), .B_BE(b_be), .B_DOUT(b_dout));
  lbram_user u_user_a (.clk(clock), .ce(a_ce), .clr(a_clr), .we(a_we), .addr(a_addr), .din(a_din),
    .be(a_be), .dout(a_dout));
  lbram_user u_user_b (.clk(clock), .ce(b_ce), .clr(b_clr), .we(b_we), .addr(b_addr), .din(b_din),
    .be(b_be), .dout(b_dout));
  // ==========================================
  // helpers
  task automatic wb_cycle(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] o);
    @(posedge clock);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_adr <= a;
    wb_we <= w;
    wb_dat_i <= d;
    @(posedge clock);
    while (wb_ack !== 1'b1) @(posedge clock);
    o = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask
  function automatic logic [71:0] merge(input logic [71:0] o, input logic [71:0] n, input logic [7:0] k);
    merge = o;
    for (int i = 0; i < 8; i++) if (k[i]) merge[9*i +: 9] = n[9*i +: 9];
  endfunction
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_regs();
    wb_cycle(4'h0, 1'b0, 32'h0, r);
    `CHK(r, 32'h0000006c);
    wb_cycle(4'h4, 1'b0, 32'h0, r);
    `CHK(r[0], 1'b0);
    wb_cycle(4'hc, 1'b1, 32'hffffffff, r);
    wb_cycle(4'hc, 1'b0, 32'h0, r);
    `CHK(r, 32'h0);
  endtask
  task automatic t_tdp();
    u_user_a.write(16'h0005, x, 8'h00);
    u_user_b.read(16'h0005, 2, q);
    `CHK(q, x);
    u_user_b.write(16'h0006, y, 8'hff);
    u_user_a.read(16'h0006, 2, q);
    `CHK(q, y);
  endtask
  task automatic t_mask();
    wb_cycle(4'h0, 1'b1, 32'h0000306c, r);
    u_user_a.write(16'h0005, y, 8'h05);
    u_user_b.read(16'h0005, 2, q);
    `CHK(q, m);
  endtask
  // a_dout still holds y, so a slow path would show the stale word
  task automatic t_bypass_clear();
    wb_cycle(4'h0, 1'b1, 32'h0000316c, r);
    u_user_a.read(16'h0005, 1, q);
    `CHK(q, m);
    u_user_a.clear(q);
    `CHK(q, 72'h0);
    u_user_a.read(16'h0005, 1, q);
    `CHK(q, m);
    u_user_b.clear(q);
    `CHK(q, 72'h0);
  endtask
  // last entry is the refused wide true dual-port layout
  task automatic t_modes();
    logic [31:0] cfg[4] = '{32'h91, 32'h61, 32'h71, 32'h70};
    logic exp_bad[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 4; i++) begin
      wb_cycle(4'h0, 1'b1, cfg[i], r);
      wb_cycle(4'h4, 1'b0, 32'h0, r);
      `CHK(r[0], exp_bad[i]);
    end
    u_user_a.write(16'h0005, x, 8'hff);
    wb_cycle(4'h0, 1'b1, 32'h0000306c, r);
    u_user_b.read(16'h0005, 2, q);
    `CHK(q, m);
  endtask
  // pin addresses are ignored; words leave in push order
  task automatic t_fifo();
    wb_cycle(4'h0, 1'b1, 32'h0000006f, r);
    u_user_a.write(16'h0123, x, 8'hff);
    u_user_a.write(16'h0456, y, 8'hff);
    wb_cycle(4'h8, 1'b0, 32'h0, r);
    `CHK(r, 32'h00000002);
    u_user_b.read(16'h0789, 2, q);
    `CHK(q, x);
    u_user_b.read(16'h0789, 2, q);
    `CHK(q, y);
    wb_cycle(4'h4, 1'b0, 32'h0, r);
    `CHK(r[2:0], 3'h2);
  endtask
  // ==========================================
  // main sequence
  initial begin
    x = 72'h123456789abcdef012;
    y = 72'hfedcba987654321fed;
    m = merge(x, y, 8'h05);
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    t_regs();
    t_tdp();
    t_mask();
    t_bypass_clear();
    t_modes();
    t_fifo();
    wrap_up();
  end
endmodule

// ---- lbram_user.sv ----
// user logic model driving one memory port
`timescale 1ns/1ps

module lbram_user (
  // clock
  input wire logic clk,
  // request
  output logic ce,
  output logic clr,
  output logic we,
  output logic [15:0] addr,
  output logic [71:0] din,
  output logic [7:0] be,
  // answer
  input wire logic [71:0] dout
);
  initial begin
    ce = 1'b0;
    clr = 1'b0;
    we = 1'b0;
    addr = 16'h0;
    din = 72'h0;
    be = 8'hff;
  end
  // ==========================================
  // released lines show the inverse, not a stale copy
  task automatic write(input logic [15:0] a, input logic [71:0] d, input logic [7:0] m);
    @(posedge clk);
    ce <= 1'b1;
    we <= 1'b1;
    addr <= a;
    din <= d;
    be <= m;
    @(posedge clk);
    ce <= 1'b0;
    addr <= ~a;
    din <= ~d;
  endtask
  task automatic read(input logic [15:0] a, input int lat, output logic [71:0] d);
    @(posedge clk);
    ce <= 1'b1;
    we <= 1'b0;
    addr <= a;
    @(posedge clk);
    ce <= 1'b0;
    addr <= ~a;
    repeat (lat) @(posedge clk);
    #1 d = dout;
  endtask
  // samples the output a quarter cycle after the edge, before any edge could act
  task automatic clear(output logic [71:0] d);
    @(posedge clk);
    clr <= 1'b1;
    #2 d = dout;
    @(posedge clk);
    clr <= 1'b0;
  endtask
endmodule
